//--- spisp_params.svh
`ifndef SPISP_PARAMS_SVH
`define SPISP_PARAMS_SVH

// ****************************************************************
// Timing and sizing constants
// ****************************************************************
`define SPISP_WORD_W 16
`define SPISP_TX_DEPTH 4
`define SPISP_BASE_LAST 2'h3
`define SPISP_EDGES_BYTE 6'h10
`define SPISP_EDGES_WORD 6'h20
`define SPISP_SEC_BASE 10'h008
`define SPISP_PRI_X64 10'h040
`define SPISP_PRI_X16 10'h010
`define SPISP_PRI_X4 10'h004
`define SPISP_PRI_X1 10'h001

// ****************************************************************
// Reset values
// ****************************************************************
`define SPISP_WORD_RESET 16'h0000

`endif

//--- spisp_pkg.sv
package spisp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } spisp_mode_t;

  typedef struct packed {
    logic enable;
    logic master;
    logic word_width_select;
    logic clock_polarity_select;
    logic clock_edge_select;
    logic slave_select_enable;
    logic [1:0] primary_prescale;
    logic [2:0] secondary_prescale;
  } spisp_cfg_t;

  typedef struct packed {
    logic rx_full;
    logic receive_overflow_flag;
    logic port_done_flag;
  } spisp_status_t;

  typedef struct packed {
    spisp_mode_t state;
    logic [15:0] serial_shift_register;
    logic [15:0] receive_buffer;
    logic [5:0] cnt;
    logic [1:0] base;
    logic [9:0] pre;
    logic sck;
    logic sdo;
    logic loaded;
    logic rx_full;
    logic ovf;
    logic done;
    logic ww;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic ss_s1;
    logic ss_s2;
  } spisp_state_t;

endpackage : spisp_pkg

//--- spisp_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module spisp_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } spisp_fifo_state_t;

  spisp_fifo_state_t s;
  spisp_fifo_state_t n;
  logic full;
  logic empty;

  // Pointers carry one extra wrap bit so full and empty are told apart.
  assign empty = (s.wp == s.rp);
  assign full = (s.wp[AW-1:0] == s.rp[AW-1:0]) && (s.wp[AW] != s.rp[AW]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = s.mem[s.rp[AW-1:0]];

  always_comb
  begin
    n = s;
    if (i_in_valid && !full)
    begin
      n.mem[s.wp[AW-1:0]] = i_in_data;
      n.wp = s.wp + {{AW{1'b0}}, 1'b1};
    end
    if (i_out_ready && !empty)
    begin
      n.rp = s.rp + {{AW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

endmodule : spisp_fifo

`default_nettype wire

//--- spisp_port.sv
`include "spisp_params.svh"
`timescale 1ns/100ps
`default_nettype none

module spisp_port
  import spisp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire spisp_cfg_t i_cfg,
  input wire logic i_wr_valid,
  input wire logic [`SPISP_WORD_W-1:0] i_wr_data,
  output logic o_wr_ready,
  input wire logic i_rd_strobe,
  output logic [`SPISP_WORD_W-1:0] o_rd_data,
  input wire logic i_done_clear,
  input wire logic i_irq_enable,
  output logic o_irq,
  output spisp_status_t o_status,
  input wire logic i_shift_clock,
  output logic o_shift_clock,
  output logic o_shift_clock_oe,
  input wire logic i_serial_data_in,
  output logic o_serial_data_out,
  output logic o_serial_data_oe,
  input wire logic i_slave_select_n
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic msb_of(input logic [15:0] v, input logic ww);
    msb_of = ww ? v[15] : v[7];
  endfunction : msb_of

  function automatic logic [5:0] edges_of(input logic ww);
    edges_of = ww ? `SPISP_EDGES_WORD : `SPISP_EDGES_BYTE;
  endfunction : edges_of

  function automatic logic [9:0] limit_of(input logic [1:0] p, input logic [2:0] q);
    logic [9:0] pf;
    pf = `SPISP_PRI_X1;
    unique case (p)
      2'h0: pf = `SPISP_PRI_X64;
      2'h1: pf = `SPISP_PRI_X16;
      2'h2: pf = `SPISP_PRI_X4;
      2'h3: pf = `SPISP_PRI_X1;
    endcase
    limit_of = pf * (`SPISP_SEC_BASE - {7'h00, q});
  endfunction : limit_of

  spisp_state_t s;
  spisp_state_t n;
  logic tx_valid;
  logic [15:0] tx_data;
  logic pop;
  logic edge_ev;
  logic smp;
  logic chg;
  logic leading;
  logic word_done;
  logic done_evt;
  logic ss_idle;
  logic abort;
  logic load_idle;
  logic [5:0] total;
  logic [9:0] limit;
  logic [15:0] shifted;
  logic [15:0] rx_word;

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************
  // shared data port
  spisp_fifo #(
    .W(`SPISP_WORD_W),
    .D(`SPISP_TX_DEPTH)
  ) u_tx_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(i_wr_valid),
    .o_in_ready(o_wr_ready),
    .i_in_data(i_wr_data),
    .o_out_valid(tx_valid),
    .i_out_ready(pop),
    .o_out_data(tx_data)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    n = s;
    n.sck_s1 = i_shift_clock;
    n.sck_s2 = s.sck_s1;
    n.sck_s3 = s.sck_s2;
    n.sdi_s1 = i_serial_data_in;
    n.sdi_s2 = s.sdi_s1;
    n.ss_s1 = i_slave_select_n;
    n.ss_s2 = s.ss_s1;
    n.ww = i_cfg.word_width_select;
    pop = 1'b0;
    edge_ev = 1'b0;
    total = edges_of(s.ww);
    limit = limit_of(i_cfg.primary_prescale, i_cfg.secondary_prescale);
    ss_idle = i_cfg.slave_select_enable && s.ss_s2;
    // A width change mid-word would misalign the counters, so it aborts.
    abort = !i_cfg.enable || (i_cfg.word_width_select != s.ww);
    if (i_cfg.master && s.state == ST_SHIFT)
    begin
      n.base = s.base + 2'h1;
      if (s.base == `SPISP_BASE_LAST)
      begin
        if (s.pre >= limit - 10'h001)
        begin
          n.pre = 10'h000;
          edge_ev = 1'b1;
        end
        else
        begin
          n.pre = s.pre + 10'h001;
        end
      end
    end
    else if (!i_cfg.master)
    begin
      n.base = 2'h0;
      n.pre = 10'h000;
      edge_ev = !s.ovf && !ss_idle && (s.sck_s2 != s.sck_s3);
    end
    else
    begin
      n.base = 2'h0;
      n.pre = 10'h000;
    end
    leading = (s.cnt[0] == 1'b0);
    smp = edge_ev && (leading == i_cfg.clock_edge_select);
    chg = edge_ev && !smp;
    if (edge_ev)
    begin
      n.cnt = s.cnt + 6'h01;
      if (i_cfg.master)
      begin
        n.sck = !s.sck;
      end
      if (s.cnt == total - 6'h01)
      begin
        n.cnt = 6'h00;
        n.state = ST_IDLE;
      end
    end
    shifted = {s.serial_shift_register[14:0], s.sdi_s2};
    rx_word = s.ww ? shifted : {8'h00, shifted[7:0]};
    if (chg)
    begin
      n.sdo = msb_of(s.serial_shift_register, s.ww);
    end
    if (smp)
    begin
      n.serial_shift_register = shifted;
    end
    word_done = smp && (s.cnt == total - {5'h00, i_cfg.clock_edge_select} - 6'h01);
    done_evt = i_cfg.master ? (edge_ev && s.cnt == total - 6'h02) : word_done;
    if (i_rd_strobe)
    begin
      n.rx_full = 1'b0;
      n.ovf = 1'b0;
    end
    if (word_done)
    begin
      n.loaded = 1'b0;
      if (s.rx_full && !i_rd_strobe)
      begin
        n.ovf = 1'b1;
      end
      else
      begin
        n.receive_buffer = rx_word;
        n.rx_full = 1'b1;
      end
    end
    load_idle = !s.loaded && !s.ovf && s.state == ST_IDLE && s.cnt == 6'h00 && !edge_ev;
    if (tx_valid && (word_done || load_idle))
    begin
      pop = 1'b1;
      n.serial_shift_register = tx_data;
      n.loaded = 1'b1;
      n.sdo = msb_of(tx_data, s.ww);
    end
    if (i_cfg.master && s.state == ST_IDLE && s.loaded && !s.ovf)
    begin
      n.state = ST_SHIFT;
    end
    if (!i_cfg.master || s.state == ST_IDLE)
    begin
      n.sck = i_cfg.clock_polarity_select;
    end
    if (!i_cfg.master && ss_idle)
    begin
      n.cnt = 6'h00;
    end
    if (abort)
    begin
      n.state = ST_IDLE;
      n.cnt = 6'h00;
      n.base = 2'h0;
      n.pre = 10'h000;
      n.sck = i_cfg.clock_polarity_select;
    end
    if (i_done_clear)
    begin
      n.done = 1'b0;
    end
    if (done_evt)
    begin
      n.done = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s <= '0;
      s.state <= ST_IDLE;
      s.serial_shift_register <= `SPISP_WORD_RESET;
      s.receive_buffer <= `SPISP_WORD_RESET;
      s.ss_s1 <= 1'b1;
      s.ss_s2 <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // gated interrupt
  assign o_irq = s.done && i_irq_enable;
  assign o_rd_data = s.receive_buffer;
  assign o_status = '{rx_full: s.rx_full, receive_overflow_flag: s.ovf, port_done_flag: s.done};
  assign o_shift_clock = s.sck;
  assign o_shift_clock_oe = i_cfg.enable && i_cfg.master;
  assign o_serial_data_out = s.sdo;
  assign o_serial_data_oe = i_cfg.enable && (i_cfg.master || !ss_idle);

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_irq_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (done_evt && !i_done_clear) ##1 i_irq_enable |-> o_irq)
    else $error("Interrupt missing after completion.");

  a_copy_word: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (word_done && !s.rx_full) |=> (s.rx_full && s.receive_buffer == $past(rx_word)))
    else $error("Received word not copied.");

  a_overflow_drop: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (word_done && s.rx_full && !i_rd_strobe) |=> (s.ovf && $stable(s.receive_buffer)))
    else $error("Overflow not flagged or buffer overwritten.");

  a_overflow_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (s.ovf && !i_rd_strobe) |=> $stable(s.serial_shift_register))
    else $error("Shift register moved during overflow.");

  a_master_start: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_cfg.master && !abort && s.state == ST_IDLE && s.loaded && !s.ovf) |=> s.state == ST_SHIFT)
    else $error("Master did not start with data loaded.");

  a_edge_total: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_cfg.master && !abort && s.state == ST_SHIFT && edge_ev && s.cnt == total - 6'h01) |=>
    (s.state == ST_IDLE && s.cnt == 6'h00))
    else $error("Master word did not end after the full edge count.");

  a_idle_level: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (s.state == ST_IDLE && !s.loaded) ##1 (s.state == ST_IDLE) |-> o_shift_clock == $past(i_cfg.clock_polarity_select))
    else $error("Shift clock not at idle level.");

  a_ss_release: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!i_cfg.master && i_cfg.slave_select_enable && s.ss_s2) |=> (s.cnt == 6'h00))
    else $error("Counters not reset on slave select release.");

  a_ss_output: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (!i_cfg.master && i_cfg.slave_select_enable && s.ss_s2) |-> !o_serial_data_oe)
    else $error("Data output driven while deselected.");

  a_change_edge: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (smp && !pop) |=> $stable(s.sdo))
    else $error("Data output changed on sample edge.");

endmodule : spisp_port

`default_nettype wire

//--- spisp_peer.sv
`timescale 1ns/100ps
`default_nettype none

module spisp_peer (
  input wire logic i_ref_clk,
  input wire logic i_sck,
  input wire logic i_sdo,
  input wire logic i_cpol,
  input wire logic i_cke,
  output logic o_sdi,
  output logic o_sck,
  output logic o_ss_n
);
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  int nb;

  initial
  begin
    tx_q = 16'h0000;
    rx_q = 16'h0000;
    nb = 8;
    o_sck = 1'b0;
    o_ss_n = 1'b1;
  end

  always @(i_sck)
  begin
    if ((i_sck != i_cpol) == i_cke)
      rx_q = {rx_q[14:0], i_sdo};
    else
      tx_q = tx_q << 1;
  end

  // first bit out is the top one.
  assign o_sdi = tx_q[nb-1];

  task automatic load(input logic [15:0] w, input int n);
    tx_q = w;
    rx_q = 16'h0000;
    nb = n;
  endtask : load

  // external clock inside a select frame.
  task automatic frame(input int edges, input int half);
    o_ss_n <= 1'b0;
    repeat (half) @(posedge i_ref_clk);
    for (int i = 0; i < edges; i++)
    begin
      o_sck <= ~o_sck;
      repeat (half) @(posedge i_ref_clk);
    end
    o_ss_n <= 1'b1;
    repeat (half) @(posedge i_ref_clk);
  endtask : frame
endmodule : spisp_peer

`default_nettype wire

//--- spi_serial_port_tb.sv
`timescale 1ns/100ps
`default_nettype none

module spi_serial_port_tb;
  import spisp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  spisp_cfg_t cfg;
  logic wr_valid;
  logic [15:0] wr_data;
  logic wr_ready;
  logic rd_strobe;
  logic [15:0] rd_data;
  logic done_clear;
  logic irq_en;
  logic irq;
  spisp_status_t status;
  logic sck_o;
  logic sck_oe;
  logic sdo;
  logic sdo_oe;
  logic sdi;
  logic peer_sck;
  logic ss_n;
  wire logic sck_w;
  wire logic sdo_w;
  int errors = 0;
  int n_compared = 0;

  always #25 clk = ~clk;
  assign sck_w = sck_oe ? sck_o : peer_sck;
  // The data line has a pull-up while released.
  assign sdo_w = sdo_oe ? sdo : 1'b1;

  spisp_port u_spisp_port (.i_ref_clk(clk), .i_reset_n(rst_n), .i_cfg(cfg), .i_wr_valid(wr_valid),
    .i_wr_data(wr_data), .o_wr_ready(wr_ready), .i_rd_strobe(rd_strobe), .o_rd_data(rd_data),
    .i_done_clear(done_clear), .i_irq_enable(irq_en), .o_irq(irq), .o_status(status),
    .i_shift_clock(sck_w), .o_shift_clock(sck_o), .o_shift_clock_oe(sck_oe), .i_serial_data_in(sdi),
    .o_serial_data_out(sdo), .o_serial_data_oe(sdo_oe), .i_slave_select_n(ss_n));

  spisp_peer u_spisp_peer (.i_ref_clk(clk), .i_sck(sck_w), .i_sdo(sdo_w), .i_cpol(cfg.clock_polarity_select),
    .i_cke(cfg.clock_edge_select), .o_sdi(sdi), .o_sck(peer_sck), .o_ss_n(ss_n));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic final_report;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic hang(input string msg);
    errors++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    final_report();
  endtask : hang

  task automatic wr(input logic [15:0] w);
    int k;
    // Let one edge pass so back-to-back writes never reassign valid in one step.
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_data <= w;
    for (k = 0; k < 2000; k++)
    begin
      @(negedge clk);
      if (wr_ready === 1'b1)
        break;
    end
    if (k == 2000)
      hang("write");
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] exp);
    chk(rd_data, exp, "read data");
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic wait_done;
    int k;
    for (k = 0; k < 4000; k++)
    begin
      @(negedge clk);
      if (status.port_done_flag === 1'b1)
        break;
    end
    if (k == 4000)
      hang("done");
    chk(irq, irq_en, "interrupt");
    if (cfg.master)
      chk(sck_o, !cfg.clock_polarity_select, "mid last bit");
    @(posedge clk);
    done_clear <= 1'b1;
    @(posedge clk);
    done_clear <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : wait_done

  task automatic meas(input int exp);
    logic p;
    int c;
    @(negedge clk);
    p = sck_o;
    for (c = 0; c < 2000 && sck_o === p; c++)
      @(negedge clk);
    p = sck_o;
    for (c = 0; c < 2000 && sck_o === p; c++)
      @(negedge clk);
    if (c == 2000)
      hang("clock");
    chk(16'(c), 16'(exp), "half period");
  endtask : meas

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    cfg = '0;
    cfg.enable = 1'b1;
    cfg.master = 1'b1;
    cfg.clock_edge_select = 1'b1;
    cfg.primary_prescale = 2'h3;
    cfg.secondary_prescale = 3'h7;
    wr_valid = 1'b0;
    wr_data = 16'h0000;
    rd_strobe = 1'b0;
    done_clear = 1'b0;
    irq_en = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(16'(status), 16'h0000, "status");
    chk(rd_data, 16'h0000, "buffer");
    chk(sck_o, 1'b0, "idle clock");
    chk(sck_oe, 1'b1, "clock drive");
    $display("test reset done");
    u_spisp_peer.load(16'h003C, 8);
    wr(16'h00A5);
    meas(4);
    wait_done();
    chk(u_spisp_peer.rx_q[7:0], 8'hA5, "sent byte");
    chk(status.rx_full, 1'b1, "full");
    rd(16'h003C);
    chk(16'(status), 16'h0000, "status");
    cfg.primary_prescale <= 2'h2;
    cfg.secondary_prescale <= 3'h6;
    repeat (4) @(posedge clk);
    u_spisp_peer.load(16'h0081, 8);
    wr(16'h007E);
    meas(32);
    wait_done();
    rd(16'h0081);
    $display("test master byte done");
    cfg.word_width_select <= 1'b1;
    cfg.primary_prescale <= 2'h3;
    cfg.secondary_prescale <= 3'h7;
    repeat (4) @(posedge clk);
    u_spisp_peer.load(16'hBEEF, 16);
    wr(16'h1234);
    wr(16'h5678);
    wait_done();
    rd(16'hBEEF);
    wait_done();
    chk(u_spisp_peer.rx_q, 16'h5678, "second word");
    u_spisp_peer.load(16'hCAFE, 16);
    wr(16'h9999);
    wait_done();
    chk(status.receive_overflow_flag, 1'b1, "overflow");
    chk(rd_data, 16'h0000, "kept word");
    wr(16'h4321);
    repeat (200) @(posedge clk);
    chk(status.port_done_flag, 1'b0, "blocked");
    rd(16'h0000);
    wait_done();
    chk(u_spisp_peer.rx_q, 16'h4321, "after read");
    rd(16'h0000);
    $display("test word and overflow done");
    cfg.word_width_select <= 1'b0;
    cfg.clock_edge_select <= 1'b0;
    cfg.clock_polarity_select <= 1'b1;
    cfg.primary_prescale <= 2'h1;
    irq_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk(sck_o, 1'b1, "idle high");
    u_spisp_peer.load(16'h0000, 8);
    wr(16'h00F0);
    meas(64);
    wait_done();
    repeat (70) @(posedge clk);
    chk(sck_o, 1'b1, "idle high");
    chk(u_spisp_peer.rx_q[7:0], 8'hF0, "edge select");
    rd(16'h0000);
    $display("test edge options done");
    cfg.master <= 1'b0;
    irq_en <= 1'b1;
    cfg.slave_select_enable <= 1'b1;
    cfg.clock_edge_select <= 1'b1;
    cfg.clock_polarity_select <= 1'b0;
    repeat (4) @(posedge clk);
    chk(sdo_oe, 1'b0, "released");
    chk(sck_oe, 1'b0, "clock input");
    u_spisp_peer.load(16'h00C3, 8);
    wr(16'h005A);
    u_spisp_peer.frame(16, 10);
    wait_done();
    chk(u_spisp_peer.rx_q[7:0], 8'h5A, "slave sent");
    rd(16'h00C3);
    wr(16'h0081);
    u_spisp_peer.frame(6, 10);
    chk(sdo_oe, 1'b0, "released");
    u_spisp_peer.load(16'h003C, 8);
    u_spisp_peer.frame(16, 10);
    wait_done();
    rd(16'h003C);
    $display("test slave done");
    final_report();
  end
endmodule : spi_serial_port_tb

`default_nettype wire
